// ===== hw/ssrs_speed_ref_select.v
/*
 Speed reference and control mode selection of a servo drive, with its
 parameters on an AHB-Lite slave.
 Assumes the analog references arrive already digitised in millivolts,
 with a one-cycle strobe per control cycle, and that all inputs are
 synchronous to i_clk_sys.
*/
`include "ssrs_defines.vh"

module ssrs_speed_ref_select (
   // Clock and reset
   input wire i_clk_sys,
   input wire i_rst,
   // AHB-Lite slave
   input wire i_hsel,
   input wire [31:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [2:0] i_hsize,
   input wire [31:0] i_hwdata,
   input wire i_hready,
   output reg [31:0] o_hrdata,
   output reg o_hreadyout,
   output reg o_hresp,
   // Analog samples and contact input
   input wire i_sample_valid,
   input wire signed [15:0] i_vref_mv,
   input wire signed [15:0] i_tref_mv,
   input wire i_mode_aux_switch_input_n,
   // Control outputs
   output reg o_cmd_valid,
   output reg [1:0] o_loop,
   output reg signed [15:0] o_speed_cmd,
   output reg [11:0] o_speed_limit,
   output reg o_speed_limit_en,
   output reg o_p_only,
   output reg signed [15:0] o_torque_ref,
   output reg o_torque_ref_en,
   output reg o_torque_ff_en,
   output reg o_torque_limit_en,
   output reg o_preset_reverse,
   output reg o_zero_clamp,
   output reg o_pulse_inhibit,
   output reg o_step_change
);

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   // Gain and maximum speed saturate rather than wrap beyond their range; the
   // fixed level keeps only write bits 11:0 before it saturates, so it can wrap.
   function [11:0] ssrs_clamp12;
      input [31:0] v;
      begin
         if (v > {20'h00000, `SSRS_SPD_MAX}) begin
            ssrs_clamp12 = `SSRS_SPD_MAX;
         end else begin
            ssrs_clamp12 = v[11:0];
         end
      end
   endfunction

   // Voltage in millivolts times gain in (r/min)/V, result in r/min.
   function signed [15:0] ssrs_scale;
      input signed [15:0] mv;
      input [11:0] gain;
      reg signed [28:0] prod;
      reg signed [28:0] quot;
      begin
         prod = mv * $signed({1'b0, gain});
         quot = prod / $signed(`SSRS_MV_PER_V);
         ssrs_scale = quot[15:0];
      end
   endfunction

   // -----------------------------------------------------------------
   // Parameter registers
   // -----------------------------------------------------------------
   reg [3:0] mode_r;
   reg [11:0] gain_r;
   reg spdlim_en_r;
   reg tlim_sel_r;
   reg ff_sel_r;
   reg [11:0] maxspd_r;
   reg [11:0] fixed_lvl_r;
   reg fixed_dir_r;

   // -----------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // -----------------------------------------------------------------
   reg wr_pend_r;
   reg [7:0] wr_addr_r;
   wire addr_phase;
   wire [7:0] rd_addr;
   reg [31:0] rd_data;
   wire aux_on;
   reg aux_r;

   assign addr_phase = i_hsel & i_hready & i_htrans[1];
   assign rd_addr = {i_haddr[7:2], 2'b00};

   always @* begin
      rd_data = 32'h00000000;
      case (rd_addr)
         `SSRS_OFS_MODE: begin
            rd_data = {28'h0000000, mode_r};
         end
         `SSRS_OFS_GAIN: begin
            rd_data = {20'h00000, gain_r};
         end
         `SSRS_OFS_TCFG: begin
            rd_data = {29'h00000000, ff_sel_r, tlim_sel_r, spdlim_en_r};
         end
         `SSRS_OFS_MAXSPD: begin
            rd_data = {20'h00000, maxspd_r};
         end
         `SSRS_OFS_FIXED: begin
            rd_data = {15'h0000, fixed_dir_r, 4'h0, fixed_lvl_r};
         end
         `SSRS_OFS_STATUS: begin
            rd_data = {20'h00000, o_step_change, o_pulse_inhibit,
                       o_zero_clamp, o_preset_reverse,
                       o_torque_limit_en, o_torque_ff_en,
                       o_torque_ref_en, o_p_only, aux_r, o_loop,
                       o_cmd_valid};
         end
         `SSRS_OFS_SPDCMD: begin
            rd_data = {{16{o_speed_cmd[15]}}, o_speed_cmd};
         end
         `SSRS_OFS_LIMIT: begin
            rd_data = {19'h00000, o_speed_limit_en, o_speed_limit};
         end
         default: begin
            rd_data = 32'h00000000;
         end
      endcase
   end

   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         o_hrdata <= 32'h00000000;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         if (i_hready) begin
            wr_pend_r <= addr_phase & i_hwrite;
            wr_addr_r <= rd_addr;
         end
         if (addr_phase & ~i_hwrite) begin
            o_hrdata <= rd_data;
         end
      end
   end

   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         mode_r <= `SSRS_MODE_RST;
         gain_r <= `SSRS_GAIN_RST;
         spdlim_en_r <= 1'b0;
         tlim_sel_r <= 1'b0;
         ff_sel_r <= 1'b0;
         maxspd_r <= `SSRS_MAXSPD_RST;
         fixed_lvl_r <= `SSRS_FIXED_RST;
         fixed_dir_r <= 1'b0;
      end else if (wr_pend_r) begin
         case (wr_addr_r)
            `SSRS_OFS_MODE: begin
               // Codes above 13 are undefined and saturate to 13.
               if (i_hwdata[31:0] > {28'h0000000, `SSRS_MODE_MAX}) begin
                  mode_r <= `SSRS_MODE_MAX;
               end else begin
                  mode_r <= i_hwdata[3:0];
               end
            end
            `SSRS_OFS_GAIN: begin
               gain_r <= ssrs_clamp12(i_hwdata);
            end
            `SSRS_OFS_TCFG: begin
               spdlim_en_r <= i_hwdata[`SSRS_TCFG_SPDLIM_EN];
               tlim_sel_r <= i_hwdata[`SSRS_TCFG_TLIM_SEL];
               ff_sel_r <= i_hwdata[`SSRS_TCFG_FF_SEL];
            end
            `SSRS_OFS_MAXSPD: begin
               maxspd_r <= ssrs_clamp12(i_hwdata);
            end
            `SSRS_OFS_FIXED: begin
               fixed_lvl_r <= ssrs_clamp12({20'h00000,
                                            i_hwdata[11:0]});
               fixed_dir_r <= i_hwdata[`SSRS_FIXED_DIR];
            end
            default: begin
               mode_r <= mode_r;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Mode decode and command computation
   // -----------------------------------------------------------------
   // The pin is driven low to assert, so a released pin reads as off.
   assign aux_on = ~i_mode_aux_switch_input_n;

   reg [1:0] loop_nxt;
   reg signed [15:0] speed_nxt;
   reg [11:0] limit_nxt;
   reg limit_en_nxt;
   reg p_only_nxt;
   reg tref_en_nxt;
   reg ff_en_nxt;
   reg tlim_en_nxt;
   reg prev_nxt;
   reg zclamp_nxt;
   reg inhibit_nxt;
   reg step_nxt;
   reg signed [15:0] analog_spd;
   reg [11:0] pos_lim;

   always @* begin
      analog_spd = ssrs_scale(i_vref_mv, gain_r);
      if (analog_spd[15]) begin
         pos_lim = 12'h000;
      end else if (analog_spd > $signed({4'h0, maxspd_r})) begin
         pos_lim = maxspd_r;
      end else begin
         pos_lim = analog_spd[11:0];
      end
      loop_nxt = `SSRS_LOOP_IDLE;
      speed_nxt = 16'sh0000;
      limit_nxt = maxspd_r;
      limit_en_nxt = 1'b0;
      p_only_nxt = 1'b0;
      tref_en_nxt = 1'b0;
      ff_en_nxt = 1'b0;
      tlim_en_nxt = 1'b0;
      prev_nxt = 1'b0;
      zclamp_nxt = 1'b0;
      inhibit_nxt = 1'b0;
      step_nxt = 1'b0;
      case (mode_r)
         4'h0, 4'h4: begin
            loop_nxt = `SSRS_LOOP_SPEED;
            speed_nxt = analog_spd;
            p_only_nxt = aux_on & (mode_r == 4'h0);
            prev_nxt = aux_on & (mode_r == 4'h4);
         end
         4'h1: begin
            p_only_nxt = aux_on;
         end
         4'h3, 4'h5, 4'h6: begin
            prev_nxt = aux_on;
         end
         4'h7, 4'h8: begin
            // No P/PI switching here: the input only picks the loop.
            if (aux_on) begin
               loop_nxt = `SSRS_LOOP_SPEED;
               speed_nxt = (mode_r == 4'h7) ? analog_spd : 16'sh0000;
            end else begin
               loop_nxt = `SSRS_LOOP_POS;
            end
         end
         4'h9: begin
            if (aux_on) begin
               loop_nxt = `SSRS_LOOP_SPEED;
               speed_nxt = analog_spd;
            end else begin
               loop_nxt = `SSRS_LOOP_TORQUE;
               tref_en_nxt = 1'b1;
               limit_en_nxt = 1'b1;
               if (spdlim_en_r) begin
                  limit_nxt = pos_lim;
               end
            end
         end
         4'hA: begin
            loop_nxt = `SSRS_LOOP_SPEED;
            speed_nxt = analog_spd;
            zclamp_nxt = aux_on;
         end
         4'hB: begin
            inhibit_nxt = aux_on;
         end
         4'hC: begin
            step_nxt = aux_on;
         end
         4'hD: begin
            // The contact input has no meaning in this mode.
            loop_nxt = `SSRS_LOOP_SPEED;
            if (fixed_dir_r) begin
               speed_nxt = -$signed({4'h0, fixed_lvl_r});
            end else begin
               speed_nxt = $signed({4'h0, fixed_lvl_r});
            end
         end
         default: begin
            loop_nxt = `SSRS_LOOP_IDLE;
         end
      endcase
      // Torque input use during analog speed control; feed-forward
      // takes precedence over the limit when both are selected.
      if ((loop_nxt == `SSRS_LOOP_SPEED) && (mode_r != 4'hD)) begin
         ff_en_nxt = ff_sel_r;
         tlim_en_nxt = tlim_sel_r & ~ff_sel_r;
      end
   end

   // -----------------------------------------------------------------
   // Per-sample output update
   // -----------------------------------------------------------------
   // Control outputs other than o_cmd_valid change only on a sample strobe so that all
   // of them belong to the same control cycle; between strobes they hold, while
   // o_cmd_valid is high for the one cycle after each strobe.
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_cmd_valid <= 1'b0;
         o_loop <= `SSRS_LOOP_IDLE;
         o_speed_cmd <= 16'sh0000;
         o_speed_limit <= `SSRS_MAXSPD_RST;
         o_speed_limit_en <= 1'b0;
         o_p_only <= 1'b0;
         o_torque_ref <= 16'sh0000;
         o_torque_ref_en <= 1'b0;
         o_torque_ff_en <= 1'b0;
         o_torque_limit_en <= 1'b0;
         o_preset_reverse <= 1'b0;
         o_zero_clamp <= 1'b0;
         o_pulse_inhibit <= 1'b0;
         o_step_change <= 1'b0;
         aux_r <= 1'b0;
      end else begin
         o_cmd_valid <= i_sample_valid;
         if (i_sample_valid) begin
            aux_r <= aux_on;
            o_loop <= loop_nxt;
            o_speed_cmd <= speed_nxt;
            o_speed_limit <= limit_nxt;
            o_speed_limit_en <= limit_en_nxt;
            o_p_only <= p_only_nxt;
            // Torque input is passed on only when some use is selected.
            if (tref_en_nxt | ff_en_nxt | tlim_en_nxt) begin
               o_torque_ref <= i_tref_mv;
            end else begin
               o_torque_ref <= 16'sh0000;
            end
            o_torque_ref_en <= tref_en_nxt;
            o_torque_ff_en <= ff_en_nxt;
            o_torque_limit_en <= tlim_en_nxt;
            o_preset_reverse <= prev_nxt;
            o_zero_clamp <= zclamp_nxt;
            o_pulse_inhibit <= inhibit_nxt;
            o_step_change <= step_nxt;
         end
      end
   end

endmodule

// ===== hw/ssrs_defines.vh
/*
 Constants for the servo speed reference select block: register byte
 offsets, field positions, reset values, ranges and control loop codes.
 Assumes the includer uses these names only as constants.
*/
// What this block does
// - Analog speed command in modes 0,4,7,9,10.
// - Speed follows input voltage; sign sets direction.
// - Gain in (r/min)/V, 0 to 2500, default 150.
// - Default gain: 10 V gives 1500 r/min.
// - Mode select 0 to 13, default 0.
// - Mode 0: aux off PI, on P only.
// - Mode 7: aux off position, on speed.
// - Mode 7: aux never switches P/PI.
// - Mode 9: aux off torque, on speed.
// - Torque mode limit enable: limit from positive input.
// - Torque mode speed capped by maximum limit.
// - Speed mode, both selects 0: torque ignored.
// - Feed-forward select 1: torque input added forward.
// - Limit select 1, feed-forward 0: torque limit.
// - Aux meaning by mode: P/PI, direction, switch.
// - Modes 10,11,12: clamp, inhibit, step change.
// - Mode 13: run fixed level, fixed direction.
// - Fixed level r/min 0 to 2500, default 500.
// - Contact input high is off, low is on.
`ifndef SSRS_DEFINES_VH
`define SSRS_DEFINES_VH
// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define SSRS_OFS_MODE 8'h00
`define SSRS_OFS_GAIN 8'h04
`define SSRS_OFS_TCFG 8'h08
`define SSRS_OFS_MAXSPD 8'h0C
`define SSRS_OFS_FIXED 8'h10
`define SSRS_OFS_STATUS 8'h14
`define SSRS_OFS_SPDCMD 8'h18
`define SSRS_OFS_LIMIT 8'h1C
// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define SSRS_TCFG_SPDLIM_EN 0
`define SSRS_TCFG_TLIM_SEL 1
`define SSRS_TCFG_FF_SEL 2
`define SSRS_FIXED_DIR 16
// -----------------------------------------------------------------
// Reset values and ranges
// -----------------------------------------------------------------
`define SSRS_MODE_RST 4'h0
`define SSRS_MODE_MAX 4'hD
`define SSRS_GAIN_RST 12'h096
`define SSRS_SPD_MAX 12'h9C4
`define SSRS_FIXED_RST 12'h1F4
`define SSRS_MAXSPD_RST 12'h9C4
`define SSRS_MV_PER_V 29'h000003E8
// -----------------------------------------------------------------
// Active control loop codes
// -----------------------------------------------------------------
`define SSRS_LOOP_IDLE 2'h0
`define SSRS_LOOP_SPEED 2'h1
`define SSRS_LOOP_POS 2'h2
`define SSRS_LOOP_TORQUE 2'h3
`endif

// ===== dv/ssrs_speed_ref_select_asserts.sv
/*
 Port checker for the speed reference select block.
 Assumes one clock and a synchronous, active-high reset.
*/
`include "ssrs_defines.vh"

module ssrs_sva (
   // Clock and reset
   input wire i_clk_sys,
   input wire i_rst,
   // Inputs watched
   input wire i_sample_valid,
   input wire signed [15:0] i_tref_mv,
   input wire i_mode_aux_switch_input_n,
   // Outputs watched
   input wire o_hreadyout,
   input wire o_hresp,
   input wire o_cmd_valid,
   input wire [1:0] o_loop,
   input wire signed [15:0] o_speed_cmd,
   input wire [11:0] o_speed_limit,
   input wire o_speed_limit_en,
   input wire o_p_only,
   input wire signed [15:0] o_torque_ref,
   input wire o_torque_ref_en,
   input wire o_torque_ff_en,
   input wire o_torque_limit_en,
   input wire o_preset_reverse,
   input wire o_zero_clamp,
   input wire o_pulse_inhibit,
   input wire o_step_change
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   wire tq_use = o_torque_ref_en | o_torque_ff_en | o_torque_limit_en;
   wire aux_any = o_p_only | o_preset_reverse | o_zero_clamp |
      o_pulse_inhibit | o_step_change;
   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   bus_okay_a: assert property (o_hreadyout && !o_hresp)
      else $error("bus slave stalled or answered with an error");
   cmd_pulse_a: assert property (
      o_cmd_valid == $past(i_sample_valid))
      else $error("command strobe does not follow the sample strobe");
   cmd_hold_a: assert property (
      !i_sample_valid |=> $stable(o_speed_cmd) && $stable(o_loop))
      else $error("command changed without a sample");
   torque_copy_a: assert property (
      i_sample_valid |=> (tq_use ? o_torque_ref == $past(i_tref_mv)
      : o_torque_ref == 16'sh0000))
      else $error("torque reference not copied or not zeroed");
   torque_loop_a: assert property (
      o_loop == `SSRS_LOOP_TORQUE |-> o_torque_ref_en && o_speed_limit_en
      && o_speed_cmd == 16'sh0000)
      else $error("torque loop without torque use or speed limit");
   ff_excl_a: assert property (
      !(o_torque_ff_en && o_torque_limit_en))
      else $error("feed-forward and torque limit both enabled");
   not_speed_a: assert property (
      o_loop != `SSRS_LOOP_SPEED |-> o_speed_cmd == 16'sh0000 &&
      !o_torque_ff_en && !o_torque_limit_en)
      else $error("speed command outside the speed loop");
   limit_range_a: assert property (
      o_speed_limit <= 12'h9C4 && (o_speed_limit_en ==
      (o_loop == `SSRS_LOOP_TORQUE)))
      else $error("speed limit out of range or enabled wrongly");
   pin_off_a: assert property (
      i_sample_valid && i_mode_aux_switch_input_n |=> !aux_any)
      else $error("contact high read as on");
   cover property (o_loop == `SSRS_LOOP_TORQUE);
   cover property (o_loop == `SSRS_LOOP_POS);
   cover property (o_torque_ff_en);
   cover property (o_p_only);
endmodule

bind ssrs_speed_ref_select ssrs_sva ssrs_sva_i (.*);

// ===== dv/ssrs_host_model.sv
/*
 Host controller model: digitised analog references and the contact pin.
 Assumes the bench requests one sample per request pulse.
*/
module ssrs_host_model (
   // Clock
   input wire i_clk,
   // Requests from the bench
   input wire i_req,
   input wire signed [15:0] i_vref,
   input wire signed [15:0] i_tref,
   input wire i_aux_on,
   // Lines towards the device
   output logic o_sample_valid,
   output logic signed [15:0] o_vref_mv,
   output logic signed [15:0] o_tref_mv,
   output logic o_aux_n
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_sample_valid = 1'b0;
      o_vref_mv = 16'sh0000;
      o_tref_mv = 16'sh0000;
      o_aux_n = 1'b1;
   end
   // Outside a strobe the values are stale, so show their inverse to
   // catch a device that reads them late.
   always @(posedge i_clk) begin
      o_sample_valid <= i_req;
      o_vref_mv <= i_req ? i_vref : ~o_vref_mv;
      o_tref_mv <= i_req ? i_tref : ~o_tref_mv;
      o_aux_n <= ~i_aux_on;
   end
endmodule

// ===== dv/ssrs_speed_ref_select_tb.sv
/*
 Self-checking bench for the speed reference select block.
 Assumes the zero-wait AHB-Lite slave and one-cycle sample latency.
*/
`include "ssrs_defines.vh"

module ssrs_speed_ref_select_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk_sys, i_rst, i_hsel, i_hwrite, h_req, h_aux;
   logic [31:0] i_haddr, i_hwdata, rd;
   logic [1:0] i_htrans;
   logic [2:0] i_hsize;
   logic signed [15:0] h_v, h_t;
   wire i_hready, i_sample_valid, i_mode_aux_switch_input_n;
   wire signed [15:0] i_vref_mv, i_tref_mv, o_speed_cmd, o_torque_ref;
   wire [31:0] o_hrdata;
   wire [1:0] o_loop;
   wire [11:0] o_speed_limit;
   wire o_hreadyout, o_hresp, o_cmd_valid, o_speed_limit_en, o_p_only;
   wire o_torque_ref_en, o_torque_ff_en, o_torque_limit_en;
   wire o_preset_reverse, o_zero_clamp, o_pulse_inhibit, o_step_change;
   int err_total, checked, cyc, m, g, tc, mx, fx, dr, sp;
   assign i_hready = o_hreadyout;
   ssrs_speed_ref_select dut (.*);
   ssrs_host_model host (.i_clk(i_clk_sys), .i_req(h_req), .i_vref(h_v),
      .i_tref(h_t), .i_aux_on(h_aux), .o_sample_valid(i_sample_valid),
      .o_vref_mv(i_vref_mv), .o_tref_mv(i_tref_mv),
      .o_aux_n(i_mode_aux_switch_input_n));
   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   // -----------------------------------------------------------------
   // Checks and expectations
   // -----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, g_);
      checked++;
      if (g_ !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g_);
      end
   endtask
   function automatic logic [1:0] exp_loop(int mo, logic a);
      case (mo)
         0, 4, 10, 13: return 2'h1;
         7, 8: return a ? 2'h1 : 2'h2;
         9: return a ? 2'h1 : 2'h3;
         default: return 2'h0;
      endcase
   endfunction
   function automatic int exp_spd(int mo, logic a, int mv);
      if (exp_loop(mo, a) != 2'h1 || mo == 8) return 0;
      if (mo == 13) return dr ? -fx : fx;
      return mv * g / 1000;
   endfunction
   // -----------------------------------------------------------------
   // Bus and sample drivers
   // -----------------------------------------------------------------
   task automatic bus(input logic wr, input logic [31:0] a, wd);
      i_hsel <= 1'b1;
      i_haddr <= a;
      i_htrans <= 2'h2;
      i_hwrite <= wr;
      do @(posedge i_clk_sys); while (i_hready !== 1'b1);
      i_htrans <= 2'h0;
      i_hwdata <= wd;
      do @(posedge i_clk_sys); while (i_hready !== 1'b1);
      rd = o_hrdata;
   endtask
   task automatic cfg(input int mo, ga, t, x, f, d);
      m = mo; g = ga; tc = t; mx = x; fx = f; dr = d;
      bus(1, 32'h00, m);
      bus(1, 32'h04, g);
      bus(1, 32'h08, tc);
      bus(1, 32'h0C, mx);
      bus(1, 32'h10, {15'h0, d[0], 4'h0, f[11:0]});
   endtask
   task automatic run(input int mv, tv, input logic a);
      logic [31:0] tq;
      h_req <= 1'b1;
      h_v <= 16'(mv);
      h_t <= 16'(tv);
      h_aux <= a;
      @(posedge i_clk_sys);
      h_req <= 1'b0;
      @(posedge i_clk_sys);
      #1;
      chk("loop", exp_loop(m, a), o_loop);
      chk("speed", exp_spd(m, a, mv),
         32'(o_speed_cmd));
      chk("aux", {m <= 1 && a, m >= 3 && m <= 6 && a, m == 10 && a,
         m == 11 && a, m == 12 && a}, {o_p_only, o_preset_reverse,
         o_zero_clamp, o_pulse_inhibit,
         o_step_change});
      sp = mv * g / 1000;
      sp = tc[0] ? (sp < 0 ? 0 : (sp > mx ? mx : sp)) : mx;
      if (m == 9 && !a)
         chk("limit", {1'b1, 12'(sp)},
            {o_torque_ref_en, o_speed_limit});
      tq = {14'h0, tc[2], tc[1] & ~tc[2], tc[2:1] != 0 ? 16'(tv) : 16'h0};
      if (m == 0)
         chk("torque", tq, {14'h0, o_torque_ff_en, o_torque_limit_en,
            o_torque_ref});
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         wrap_up();
      end
   end
   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      logic [31:0] rv [6];
      i_rst = 1'b1; i_hsel = 1'b0; i_haddr = 32'h0; i_htrans = 2'h0;
      i_hwrite = 1'b0; i_hsize = 3'h2; i_hwdata = 32'h0; h_req = 1'b0;
      h_v = 16'sh0000; h_t = 16'sh0000; h_aux = 1'b0;
      void'($urandom(64));
      repeat (8) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      bus(1, 32'h20, 32'hFFFFFFFF);
      rv = '{32'h0, 32'h096, 32'h0, 32'h9C4, 32'h1F4, 32'h0};
      for (int i = 0; i < 6; i++) begin
         bus(0, i < 5 ? i * 4 : 32'h20, 32'h0);
         chk("reset value", rv[i], rd);
      end
      bus(1, 32'h00, 32'hF);
      bus(0, 32'h00, 32'h0);
      chk("mode clamp", 32'hD, rd);
      bus(1, 32'h04, 32'hFFF);
      bus(0, 32'h04, 32'h0);
      chk("gain clamp", 32'h9C4, rd);
      cfg(0, 150, 0, 2500, 500, 0);
      run(10000, 0, 0);
      run(1000, 55, 1);
      run(-3000, 0, 0);
      cfg(9, 2500, 1, 1200, 500, 0);
      run(-4000, 77, 0);
      run(9000, 77, 0);
      cfg(13, 0, 0, 2500, 2500, 1);
      run(5000, 0, 1);
      for (int i = 0; i < 28; i++) begin
         cfg(i / 2, 150, i % 8, 2500, 500, 0);
         run(2000, -900, i[0]);
      end
      for (int i = 0; i < 60; i++) begin
         cfg($urandom_range(13), $urandom_range(2500), $urandom_range(7),
            $urandom_range(2500), $urandom_range(2500), $urandom_range(1));
         run($urandom_range(20000) - 10000, $urandom_range(20000) - 10000,
            $urandom_range(1));
      end
      wrap_up();
   end
endmodule
